// file: verilog/tfc_pkg.sv
// Constants for the T1 framer control register block.
// Assumes a byte-wide parallel port synchronous to the system clock.
// Notes on behaviour
// - Identity bit 7 tells software whether this is the T1 or E1 variant.
// - Identity low nibble holds a four-bit die revision; bits 6..4 read zero.
// - Out-of-frame on 2 of 4 or 2 of 5 errors; second select forces 2 of 6.
// - Auto realign on frame loss unless the disable bit is set.
// - Rising edge of the resync bit starts one realign; clear and set to repeat.
// - Code select picks idle byte 7F or the eight-byte milliwatt sequence.
// - Receive zero byte interchange enable turns that processing on or off.
// - Double-width sync pulse in signaling frames; software keeps it off in bad modes.
// - Sync mode picks frame or multiframe marks; ignored when sync pin is input.
// - Sync direction bit: zero output, one input; input needs elastic store.
// - Receive yellow detect: bit 2 zeros, or a one in frame 12 S-bit.
// - Framing error count takes Ft errors, plus Fs errors when report enabled.
// - Multiframe counter counts framing errors or multiframes out of sync.
// - With fallback set, a stopped transmit clock moves transmit to receive clock.
// - F bits generated inside, or taken from serial input when pass-through set.
// - CRC6 computed inside, or sampled from serial input when pass-through set.
// - Software signaling insertion from signaling registers, unless transparency blocks.
// - Global bit 7 stuffing forces all-zero bytes; else transparency decides.
// - Datalink source: legacy transmit register, or controller and link pin.
// - Blue alarm sends unframed all ones on both line outputs.
// - Yellow alarm bit sends the remote alarm while set.
// - Common control elastic store bit bypasses or enables receive store.
package tfc_pkg;
  localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0F;
  localparam logic [7:0] ADDR_RECEIVE_CONTROL_A = 8'h2B;
  localparam logic [7:0] ADDR_RECEIVE_CONTROL_B = 8'h2C;
  localparam logic [7:0] ADDR_TRANSMIT_CONTROL_A = 8'h35;
  localparam logic [7:0] ADDR_COMMON_CONTROL_A = 8'h37;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Receive control A fields
  localparam int VIOLATION_COUNTER_FUNCTION = 7;
  localparam int AUTO_REALIGN_CRITERIA = 6;
  localparam int FRAME_LOSS_SELECT_A = 5;
  localparam int FRAME_LOSS_SELECT_B = 4;
  localparam int SYNC_CRITERIA = 3;
  localparam int SYNC_TIME = 2;
  localparam int AUTO_REALIGN_DISABLE = 1;
  localparam int RESYNC_REQUEST = 0;
  // Receive control B fields
  localparam int RX_CODE_SELECT = 7;
  localparam int RX_ZERO_BYTE_INTERCHANGE_EN = 6;
  localparam int RX_SYNC_DOUBLE_WIDTH = 5;
  localparam int RX_SYNC_MODE = 4;
  localparam int RX_SYNC_DIRECTION = 3;
  localparam int RX_SUPERFRAME_YELLOW_MODE = 2;
  localparam int SIGNALING_FBIT_ERROR_REPORT = 1;
  localparam int MULTIFRAME_COUNTER_FUNCTION = 0;
  // Transmit control A fields
  localparam int TX_CLOCK_FALLBACK = 7;
  localparam int TX_FBIT_PASSTHROUGH = 6;
  localparam int TX_CRC_PASSTHROUGH = 5;
  localparam int SW_SIGNALING_INSERT_EN = 4;
  localparam int GLOBAL_BIT7_STUFF = 3;
  localparam int DATALINK_SOURCE_SELECT = 2;
  localparam int TX_BLUE_ALARM = 1;
  localparam int TX_YELLOW_ALARM = 0;
  // Common control A field
  localparam int RX_ELASTIC_STORE_EN = 2;
  // Identity layout
  localparam int LINE_STANDARD_FLAG = 7;
  localparam logic [2:0] IDENTITY_PAD = 3'h0;
  // Substitution codes
  localparam logic [7:0] IDLE_CODE = 8'h7F;
  localparam logic [7:0] MW_0 = 8'h1E;
  localparam logic [7:0] MW_1 = 8'h0B;
  localparam logic [7:0] MW_4 = 8'h9E;
  localparam logic [7:0] MW_5 = 8'h8B;
  // Out-of-frame windows
  localparam logic [2:0] OOF_WINDOW_A = 3'h4;
  localparam logic [2:0] OOF_WINDOW_B = 3'h5;
  localparam logic [2:0] OOF_WINDOW_C = 3'h6;
  localparam logic [2:0] OOF_ERROR_LIMIT = 3'h2;
  // Line framing
  localparam logic [7:0] FRAME_LAST_BIT = 8'hC0;
  localparam logic [3:0] SUPERFRAME_LAST = 4'hB;
  localparam logic [11:0] SUPERFRAME_FBITS = 12'h8DC;
  localparam logic [2:0] YELLOW_BIT_SLOT = 3'h1;
  // Transmit clock loss detection
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int TX_CLOCK_LOSS_NS = 1000;
  localparam int TX_CLOCK_LOSS_CYCLES = TX_CLOCK_LOSS_NS / CLOCK_PERIOD_NS;
endpackage

// file: verilog/tfc_framer_control.sv
// Control, identity and transmit line stage for one T1 framer.
// Assumes port strobes and framer event strobes are synchronous to clock.
`timescale 1ns/1ps
module tfc_framer_control
  import tfc_pkg::*;
#(
  // Arbitrary neutral revision code
  parameter logic [3:0] DIE_REVISION = 4'h1,
  parameter logic LINE_STANDARD_E1 = 1'b0,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] port_address,
  input wire logic [7:0] port_write_data,
  input wire logic port_write,
  input wire logic port_read,
  output logic [7:0] port_read_data,
  input wire logic fbit_strobe,
  input wire logic ft_error,
  input wire logic fs_error,
  input wire logic multiframe_out_of_sync,
  input wire logic frame_found,
  input wire logic [2:0] rx_code_index,
  input wire logic rx_frame_mark,
  input wire logic rx_multiframe_mark,
  input wire logic rx_signaling_frame,
  input wire logic rx_bit2_zeros,
  input wire logic rx_sbit12_one,
  input wire logic rx_sync_pin_in,
  output logic rx_sync_pin_out,
  output logic rx_sync_pin_oe,
  output logic rx_sync_external,
  output logic rx_resync_pulse,
  output logic out_of_frame,
  output logic rx_yellow_alarm,
  output logic [7:0] rx_code_byte,
  output logic [COUNT_WIDTH-1:0] framing_error_count,
  output logic [COUNT_WIDTH-1:0] multiframe_count,
  output logic violation_counter_function,
  output logic auto_realign_criteria,
  output logic sync_criteria,
  output logic sync_time,
  output logic rx_zero_byte_interchange_en,
  output logic rx_elastic_store_en,
  output logic tx_crc_passthrough,
  output logic sw_signaling_insert_en,
  output logic global_bit7_stuff,
  output logic datalink_source_select,
  output logic tx_clock_lost,
  output logic tx_clock_on_rx,
  input wire logic tx_line_clock,
  input wire logic tx_serial_in,
  output logic tx_line_pos_out,
  output logic tx_line_neg_out
);

  typedef struct packed {
    logic [7:0] receive_control_a;
    logic [7:0] receive_control_b;
    logic [7:0] transmit_control_a;
    logic [7:0] common_control_a;
    logic [7:0] read_data;
    logic resync_prev;
    logic resync_pulse;
    logic [5:0] fbit_history;
    logic oof;
    logic [COUNT_WIDTH-1:0] framing_errors;
    logic [COUNT_WIDTH-1:0] multiframes;
    logic [7:0] code_byte;
    logic yellow;
    logic sync_out;
    logic sync_oe;
    logic mark_prev;
    logic sync_s1;
    logic sync_s2;
    logic sync_ext;
    logic toggle_s1;
    logic toggle_s2;
    logic toggle_s3;
    logic [7:0] loss_count;
    logic clock_lost;
    logic on_rx;
  } tfc_main_t;

  typedef struct packed {
    logic blue_s1;
    logic blue_s2;
    logic yellow_s1;
    logic yellow_s2;
    logic fpt_s1;
    logic fpt_s2;
    logic toggle;
    logic [7:0] bit_count;
    logic [3:0] frame_num;
    logic [2:0] ch_bit;
    logic ami_pos;
    logic pos;
    logic neg;
  } tfc_link_t;

  tfc_main_t st;
  tfc_main_t next_st;
  tfc_link_t ln;
  tfc_link_t next_ln;

  function automatic logic [7:0] milliwatt_byte(input logic [2:0] idx);
    logic [7:0] b;
    b = MW_0;
    unique case (idx[1:0])
      2'h0: b = idx[2] ? MW_4 : MW_0;
      2'h1: b = idx[2] ? MW_5 : MW_1;
      2'h2: b = idx[2] ? MW_5 : MW_1;
      2'h3: b = idx[2] ? MW_4 : MW_0;
    endcase
    return b;
  endfunction

  function automatic logic [2:0] count_errors(input logic [5:0] hist, input logic [2:0] window);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < window && hist[i]) begin
        n = 3'(n + 3'h1);
      end
    end
    return n;
  endfunction

  logic [2:0] oof_window;
  logic [5:0] hist_now;
  logic oof_detect;
  logic write_hit_a;

  always_comb begin
    next_st = st;
    write_hit_a = port_write && port_address == ADDR_RECEIVE_CONTROL_A;
    // Register writes
    if (write_hit_a) begin
      next_st.receive_control_a = port_write_data;
    end
    if (port_write && port_address == ADDR_RECEIVE_CONTROL_B) begin
      next_st.receive_control_b = port_write_data;
    end
    if (port_write && port_address == ADDR_TRANSMIT_CONTROL_A) begin
      next_st.transmit_control_a = port_write_data;
    end
    if (port_write && port_address == ADDR_COMMON_CONTROL_A) begin
      next_st.common_control_a = port_write_data;
    end
    // Register reads
    if (port_read) begin
      unique case (port_address)
        ADDR_DEVICE_IDENTITY: next_st.read_data = {LINE_STANDARD_E1, IDENTITY_PAD, DIE_REVISION};
        ADDR_RECEIVE_CONTROL_A: next_st.read_data = st.receive_control_a;
        ADDR_RECEIVE_CONTROL_B: next_st.read_data = st.receive_control_b;
        ADDR_TRANSMIT_CONTROL_A: next_st.read_data = st.transmit_control_a;
        ADDR_COMMON_CONTROL_A: next_st.read_data = st.common_control_a;
        default: next_st.read_data = UNMAPPED_READ;
      endcase
    end
    if (st.receive_control_a[FRAME_LOSS_SELECT_B]) begin
      oof_window = OOF_WINDOW_C;
    end else if (st.receive_control_a[FRAME_LOSS_SELECT_A]) begin
      oof_window = OOF_WINDOW_B;
    end else begin
      oof_window = OOF_WINDOW_A;
    end
    hist_now = fbit_strobe ? {st.fbit_history[4:0], ft_error | fs_error} : st.fbit_history;
    next_st.fbit_history = hist_now;
    oof_detect = fbit_strobe && !st.oof && count_errors(hist_now, oof_window) >= OOF_ERROR_LIMIT;
    if (oof_detect) begin
      next_st.oof = 1'b1;
    end else if (frame_found) begin
      next_st.oof = 1'b0;
      next_st.fbit_history = 6'h00;
    end
    next_st.resync_prev = st.receive_control_a[RESYNC_REQUEST];
    next_st.resync_pulse = st.receive_control_a[RESYNC_REQUEST] && !st.resync_prev;
    if (oof_detect && !st.receive_control_a[AUTO_REALIGN_DISABLE]) begin
      next_st.resync_pulse = 1'b1;
    end
    if ((ft_error && fbit_strobe) || (fs_error && fbit_strobe && st.receive_control_b[SIGNALING_FBIT_ERROR_REPORT])) begin
      next_st.framing_errors = COUNT_WIDTH'(st.framing_errors + 1'b1);
    end
    if (st.receive_control_b[MULTIFRAME_COUNTER_FUNCTION]) begin
      if (multiframe_out_of_sync) begin
        next_st.multiframes = COUNT_WIDTH'(st.multiframes + 1'b1);
      end
    end else if (fbit_strobe && (ft_error || fs_error)) begin
      next_st.multiframes = COUNT_WIDTH'(st.multiframes + 1'b1);
    end
    next_st.code_byte = st.receive_control_b[RX_CODE_SELECT] ? milliwatt_byte(rx_code_index) : IDLE_CODE;
    next_st.yellow = st.receive_control_b[RX_SUPERFRAME_YELLOW_MODE] ? rx_sbit12_one : rx_bit2_zeros;
    next_st.sync_oe = !st.receive_control_b[RX_SYNC_DIRECTION];
    if (st.receive_control_b[RX_SYNC_MODE]) begin
      next_st.sync_out = rx_multiframe_mark;
    end else begin
      next_st.sync_out = rx_frame_mark
        || (st.receive_control_b[RX_SYNC_DOUBLE_WIDTH] && rx_signaling_frame && st.mark_prev);
    end
    next_st.mark_prev = rx_frame_mark;
    next_st.sync_s1 = rx_sync_pin_in;
    next_st.sync_s2 = st.sync_s1;
    // External sync honoured only with elastic store
    next_st.sync_ext = st.sync_s2 && st.receive_control_b[RX_SYNC_DIRECTION]
      && st.common_control_a[RX_ELASTIC_STORE_EN];
    next_st.toggle_s1 = ln.toggle;
    next_st.toggle_s2 = st.toggle_s1;
    next_st.toggle_s3 = st.toggle_s2;
    if (st.toggle_s2 != st.toggle_s3) begin
      next_st.loss_count = 8'h00;
    end else if (st.loss_count != 8'(TX_CLOCK_LOSS_CYCLES)) begin
      next_st.loss_count = 8'(st.loss_count + 8'h01);
    end
    next_st.clock_lost = st.loss_count == 8'(TX_CLOCK_LOSS_CYCLES);
    next_st.on_rx = st.transmit_control_a[TX_CLOCK_FALLBACK] && st.clock_lost;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic line_data;

  always_comb begin
    next_ln = ln;
    line_data = 1'b0;
    next_ln.blue_s1 = st.transmit_control_a[TX_BLUE_ALARM];
    next_ln.blue_s2 = ln.blue_s1;
    next_ln.yellow_s1 = st.transmit_control_a[TX_YELLOW_ALARM];
    next_ln.yellow_s2 = ln.yellow_s1;
    next_ln.fpt_s1 = st.transmit_control_a[TX_FBIT_PASSTHROUGH];
    next_ln.fpt_s2 = ln.fpt_s1;
    next_ln.toggle = !ln.toggle;
    if (ln.bit_count == FRAME_LAST_BIT) begin
      next_ln.bit_count = 8'h00;
      next_ln.frame_num = ln.frame_num == SUPERFRAME_LAST ? 4'h0 : 4'(ln.frame_num + 4'h1);
    end else begin
      next_ln.bit_count = 8'(ln.bit_count + 8'h01);
    end
    if (ln.bit_count == 8'h00) begin
      next_ln.ch_bit = 3'h0;
      line_data = ln.fpt_s2 ? tx_serial_in : SUPERFRAME_FBITS[4'(SUPERFRAME_LAST - ln.frame_num)];
    end else begin
      next_ln.ch_bit = 3'(ln.ch_bit + 3'h1);
      // Remote alarm forces bit 2 low
      line_data = tx_serial_in && !(ln.yellow_s2 && ln.ch_bit == YELLOW_BIT_SLOT);
    end
    if (ln.blue_s2) begin
      next_ln.pos = 1'b1;
      next_ln.neg = 1'b1;
    end else begin
      next_ln.pos = line_data && ln.ami_pos;
      next_ln.neg = line_data && !ln.ami_pos;
      next_ln.ami_pos = line_data ? !ln.ami_pos : ln.ami_pos;
    end
  end

  always_ff @(posedge tx_line_clock or negedge reset_n) begin
    if (!reset_n) begin
      ln <= '0;
    end else begin
      ln <= next_ln;
    end
  end

  assign port_read_data = st.read_data;
  assign rx_resync_pulse = st.resync_pulse;
  assign out_of_frame = st.oof;
  assign rx_yellow_alarm = st.yellow;
  assign rx_code_byte = st.code_byte;
  assign framing_error_count = st.framing_errors;
  assign multiframe_count = st.multiframes;
  assign rx_sync_pin_out = st.sync_out;
  assign rx_sync_pin_oe = st.sync_oe;
  assign rx_sync_external = st.sync_ext;
  assign violation_counter_function = st.receive_control_a[VIOLATION_COUNTER_FUNCTION];
  assign auto_realign_criteria = st.receive_control_a[AUTO_REALIGN_CRITERIA];
  assign sync_criteria = st.receive_control_a[SYNC_CRITERIA];
  assign sync_time = st.receive_control_a[SYNC_TIME];
  assign rx_zero_byte_interchange_en = st.receive_control_b[RX_ZERO_BYTE_INTERCHANGE_EN];
  assign rx_elastic_store_en = st.common_control_a[RX_ELASTIC_STORE_EN];
  assign tx_crc_passthrough = st.transmit_control_a[TX_CRC_PASSTHROUGH];
  assign sw_signaling_insert_en = st.transmit_control_a[SW_SIGNALING_INSERT_EN];
  assign global_bit7_stuff = st.transmit_control_a[GLOBAL_BIT7_STUFF];
  assign datalink_source_select = st.transmit_control_a[DATALINK_SOURCE_SELECT];
  assign tx_clock_lost = st.clock_lost;
  assign tx_clock_on_rx = st.on_rx;
  assign tx_line_pos_out = ln.pos;
  assign tx_line_neg_out = ln.neg;

  sequence resync_rise_s;
    !st.receive_control_a[RESYNC_REQUEST] ##1 st.receive_control_a[RESYNC_REQUEST];
  endsequence

  id_read_word_a: assert property (@(posedge clock) disable iff (!reset_n)
    port_read && port_address == ADDR_DEVICE_IDENTITY |=> port_read_data == {LINE_STANDARD_E1, 3'h0, DIE_REVISION})
    else $error("identity read wrong");
  resync_edge_a: assert property (@(posedge clock) disable iff (!reset_n)
    resync_rise_s |=> rx_resync_pulse)
    else $error("resync edge lost");
  resync_level_a: assert property (@(posedge clock) disable iff (!reset_n)
    st.receive_control_a[AUTO_REALIGN_DISABLE] && $stable(st.receive_control_a) && st.resync_prev
      |=> !rx_resync_pulse)
    else $error("resync without cause");
  oof_four_a: assert property (@(posedge clock) disable iff (!reset_n)
    fbit_strobe && !out_of_frame && st.receive_control_a[5:4] == 2'h0
      && count_errors({st.fbit_history[4:0], ft_error | fs_error}, 3'h4) >= 3'h2 |=> out_of_frame)
    else $error("frame loss missed");
  idle_code_a: assert property (@(posedge clock) disable iff (!reset_n)
    !st.receive_control_b[RX_CODE_SELECT] |=> rx_code_byte == 8'h7F)
    else $error("idle code wrong");
  sync_dir_a: assert property (@(posedge clock) disable iff (!reset_n)
    st.receive_control_b[RX_SYNC_DIRECTION] |=> !rx_sync_pin_oe)
    else $error("sync pin driven as input");
  fs_count_a: assert property (@(posedge clock) disable iff (!reset_n)
    fbit_strobe && fs_error && !ft_error && !st.receive_control_b[SIGNALING_FBIT_ERROR_REPORT]
      |=> $stable(framing_error_count))
    else $error("Fs error counted");
  fallback_a: assert property (@(posedge clock) disable iff (!reset_n)
    tx_clock_on_rx |-> $past(st.transmit_control_a[TX_CLOCK_FALLBACK]) && $past(tx_clock_lost))
    else $error("fallback without cause");
  blue_line_a: assert property (@(posedge tx_line_clock) disable iff (!reset_n)
    ln.blue_s2 |=> tx_line_pos_out && tx_line_neg_out)
    else $error("blue alarm not all ones");

  sequence frame_mark_s;
    (!st.receive_control_b[RX_SYNC_MODE] && rx_frame_mark)
      ##1 (!st.receive_control_b[RX_SYNC_MODE] && !rx_frame_mark);
  endsequence

  sync_wide_a: assert property (@(posedge clock) disable iff (!reset_n)
    (frame_mark_s ##0 (st.receive_control_b[RX_SYNC_DOUBLE_WIDTH] && rx_signaling_frame))
      |=> rx_sync_pin_out)
    else $error("sync mark not widened");
  sync_single_a: assert property (@(posedge clock) disable iff (!reset_n)
    (frame_mark_s ##0 !st.receive_control_b[RX_SYNC_DOUBLE_WIDTH]) |=> !rx_sync_pin_out)
    else $error("sync mark widened");
  rx_yellow_fmt_a: assert property (@(posedge clock) disable iff (!reset_n)
    st.receive_control_b[RX_SUPERFRAME_YELLOW_MODE] |=> rx_yellow_alarm == $past(rx_sbit12_one))
    else $error("yellow source wrong");
  mf_oos_count_a: assert property (@(posedge clock) disable iff (!reset_n)
    st.receive_control_b[MULTIFRAME_COUNTER_FUNCTION] && multiframe_out_of_sync
      |=> multiframe_count == COUNT_WIDTH'($past(multiframe_count) + 1'b1))
    else $error("multiframe not counted");
  fbit_pass_a: assert property (@(posedge tx_line_clock) disable iff (!reset_n)
    ln.fpt_s2 && !ln.blue_s2 && ln.bit_count == 8'h00
      |=> (tx_line_pos_out || tx_line_neg_out) == $past(tx_serial_in))
    else $error("passed F bit wrong");
  yellow_bit_a: assert property (@(posedge tx_line_clock) disable iff (!reset_n)
    ln.yellow_s2 && !ln.blue_s2 && ln.bit_count != 8'h00 && ln.ch_bit == YELLOW_BIT_SLOT
      |=> !tx_line_pos_out && !tx_line_neg_out)
    else $error("yellow bit not low");

endmodule // tfc_framer_control

// file: dv/tfc_line_partner.sv
// Line interface model: transmit line clock and transmit serial data.
// Assumes the bench lowers run to model a failed transmit line clock.
`timescale 1ns/1ps
module tfc_line_partner (
  input wire logic run,
  output logic tx_line_clock,
  output logic tx_serial_in
);
  int seed = 84181;

  initial begin
    tx_line_clock = 1'b0;
    tx_serial_in = 1'b0;
    #3.3;
    forever begin
      #6;
      if (run) begin
        tx_line_clock = ~tx_line_clock;
        if (!tx_line_clock) begin
          tx_serial_in = 1'($random(seed));
        end
      end
    end
  end
endmodule // tfc_line_partner

// file: dv/tfc_framer_control_bench.sv
// Self-checking bench for the framer control block.
// Assumes tfc_pkg, the design and the line partner model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tfc_framer_control_bench;
  import tfc_pkg::*;
  // Arbitrary revision code
  localparam logic [3:0] REV = 4'h6;
  localparam logic [7:0] MW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
  localparam logic [7:0] OOF_CTL [4] = '{8'h00, 8'h20, 8'h12, 8'h30};
  localparam int OOF_WIN [4] = '{4, 5, 6, 6};
  localparam logic [7:0] CNT_CFG [3] = '{8'h01, 8'h03, 8'h00};
  logic clock, reset_n, port_write, port_read, fbit_strobe, ft_error, fs_error, multiframe_out_of_sync;
  logic frame_found, rx_frame_mark, rx_multiframe_mark, rx_signaling_frame, rx_bit2_zeros, rx_sbit12_one;
  logic [7:0] port_address, port_write_data, port_read_data, rx_code_byte, model_a, model_b, model_t;
  logic [2:0] rx_code_index;
  logic rx_sync_pin_in, rx_sync_pin_out, rx_sync_pin_oe, rx_sync_external, rx_resync_pulse, out_of_frame;
  logic rx_yellow_alarm, violation_counter_function, auto_realign_criteria, sync_criteria, sync_time;
  logic [15:0] framing_error_count, multiframe_count;
  logic rx_zero_byte_interchange_en, rx_elastic_store_en, tx_crc_passthrough, sw_signaling_insert_en;
  logic global_bit7_stuff, datalink_source_select, tx_clock_lost, tx_clock_on_rx;
  logic tx_line_clock, tx_serial_in, tx_line_pos_out, tx_line_neg_out, line_run, sync_drive;
  int error_cnt, comparisons, pulses, fe_cnt, mf_cnt;
  int seed = 84181;

  tfc_framer_control #(.DIE_REVISION(REV)) uut (.*);
  tfc_line_partner partner (.run(line_run), .tx_line_clock(tx_line_clock), .tx_serial_in(tx_serial_in));

  assign rx_sync_pin_in = rx_sync_pin_oe ? rx_sync_pin_out : sync_drive;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rx_resync_pulse === 1'b1) pulses++;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    port_address = a;
    port_write_data = d;
    port_write = 1'b1;
    step(1);
    port_write = 1'b0;
    if (a == ADDR_RECEIVE_CONTROL_A) model_a = d;
    if (a == ADDR_RECEIVE_CONTROL_B) model_b = d;
    if (a == ADDR_TRANSMIT_CONTROL_A) model_t = d;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    port_address = a;
    port_read = 1'b1;
    step(1);
    port_read = 1'b0;
    step(1);
    `CHK(nm, ex, port_read_data)
  endtask

  task automatic fbit(input logic ft, input logic fs);
    fbit_strobe = 1'b1;
    ft_error = ft;
    fs_error = fs;
    step(1);
    fbit_strobe = 1'b0;
    ft_error = 1'b0;
    fs_error = 1'b0;
    if (ft || (model_b[1] && fs)) fe_cnt++;
    if (!model_b[0] && (ft || fs)) mf_cnt++;
    step(1);
    `CHK("framing errors", 16'(fe_cnt), framing_error_count)
    `CHK("multiframe count", 16'(mf_cnt), multiframe_count)
  endtask

  task automatic pulse_found();
    frame_found = 1'b1;
    step(1);
    frame_found = 1'b0;
    step(1);
  endtask

  initial begin
    #1_000_000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {reset_n, port_write, port_read, fbit_strobe, ft_error, fs_error, multiframe_out_of_sync} = '0;
    {frame_found, rx_frame_mark, rx_multiframe_mark, rx_signaling_frame, rx_bit2_zeros, rx_sbit12_one} = '0;
    port_address = 8'h00;
    port_write_data = 8'h00;
    rx_code_index = 3'h0;
    {model_a, model_b, model_t} = '0;
    line_run = 1'b1;
    sync_drive = 1'b0;
    repeat (12) @(posedge clock);
    #2;
    reset_n = 1'b1;
    step(1);
    rd(ADDR_DEVICE_IDENTITY, {1'b0, 3'h0, REV}, "identity");
    rd(ADDR_RECEIVE_CONTROL_A, 8'h00, "ctl a reset");
    rd(ADDR_RECEIVE_CONTROL_B, 8'h00, "ctl b reset");
    rd(ADDR_TRANSMIT_CONTROL_A, 8'h00, "ctl t reset");
    wr(ADDR_DEVICE_IDENTITY, 8'hFF);
    rd(ADDR_DEVICE_IDENTITY, {1'b0, 3'h0, REV}, "identity ro");
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00, "unmapped");
    repeat (6) begin
      wr(ADDR_RECEIVE_CONTROL_A, 8'($random(seed)));
      wr(ADDR_RECEIVE_CONTROL_B, 8'($random(seed)) & 8'hD7);
      wr(ADDR_TRANSMIT_CONTROL_A, 8'($random(seed)));
      rd(ADDR_RECEIVE_CONTROL_A, model_a, "ctl a");
      rd(ADDR_RECEIVE_CONTROL_B, model_b, "ctl b");
      rd(ADDR_TRANSMIT_CONTROL_A, model_t, "ctl t");
      `CHK("lcv fn", model_a[7], violation_counter_function)
      `CHK("realign crit", {model_a[6], model_a[3], model_a[2]}, {auto_realign_criteria, sync_criteria, sync_time})
      `CHK("zbtsi", model_b[6], rx_zero_byte_interchange_en)
      `CHK("tx ctl", model_t[5:2], {tx_crc_passthrough, sw_signaling_insert_en, global_bit7_stuff, datalink_source_select})
    end
    wr(ADDR_RECEIVE_CONTROL_A, 8'h00);
    wr(ADDR_RECEIVE_CONTROL_B, 8'h00);
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h00);
    step(4);
    pulses = 0;
    wr(ADDR_RECEIVE_CONTROL_A, 8'h01);
    step(4);
    `CHK("resync one", 1, pulses)
    wr(ADDR_RECEIVE_CONTROL_A, 8'h01);
    step(4);
    `CHK("resync held", 1, pulses)
    wr(ADDR_RECEIVE_CONTROL_A, 8'h00);
    wr(ADDR_RECEIVE_CONTROL_A, 8'h01);
    step(4);
    `CHK("resync again", 2, pulses)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RECEIVE_CONTROL_A, OOF_CTL[i]);
      pulse_found();
      repeat (OOF_WIN[i]) fbit(1'b0, 1'b0);
      fbit(1'b1, 1'b0);
      repeat (OOF_WIN[i] - 1) fbit(1'b0, 1'b0);
      fbit(1'b1, 1'b0);
      `CHK("oof spread", 1'b0, out_of_frame)
      repeat (OOF_WIN[i]) fbit(1'b0, 1'b0);
      pulses = 0;
      fbit(1'b1, 1'b0);
      repeat (OOF_WIN[i] - 2) fbit(1'b0, 1'b0);
      fbit(1'b1, 1'b0);
      `CHK("oof window", 1'b1, out_of_frame)
      step(3);
      `CHK("auto realign", OOF_CTL[i][1] ? 0 : 1, pulses)
      pulse_found();
      `CHK("oof cleared", 1'b0, out_of_frame)
    end
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_RECEIVE_CONTROL_B, CNT_CFG[p]);
      repeat (12) begin
        fbit(1'($random(seed)), 1'($random(seed)));
        multiframe_out_of_sync = 1'b1;
        step(1);
        multiframe_out_of_sync = 1'b0;
        if (model_b[0]) mf_cnt++;
        step(1);
        `CHK("mf oos count", 16'(mf_cnt), multiframe_count)
      end
    end
    for (int cs = 0; cs < 2; cs++) begin
      wr(ADDR_RECEIVE_CONTROL_B, cs ? 8'h80 : 8'h00);
      for (int i = 0; i < 8; i++) begin
        rx_code_index = 3'(i);
        step(2);
        `CHK("code byte", cs ? MW[i] : 8'h7F, rx_code_byte)
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_RECEIVE_CONTROL_B, m ? 8'h04 : 8'h00);
      for (int k = 0; k < 4; k++) begin
        {rx_bit2_zeros, rx_sbit12_one} = 2'(k);
        step(2);
        `CHK("yellow", m ? k[0] : k[1], rx_yellow_alarm)
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_RECEIVE_CONTROL_B, m ? 8'h10 : 8'h00);
      for (int k = 0; k < 4; k++) begin
        {rx_frame_mark, rx_multiframe_mark} = 2'(k);
        step(3);
        `CHK("sync oe", 1'b1, rx_sync_pin_oe)
        `CHK("sync out", m ? k[0] : k[1], rx_sync_pin_out)
      end
    end
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_RECEIVE_CONTROL_B, w ? 8'h20 : 8'h00);
      rx_signaling_frame = 1'b1;
      rx_frame_mark = 1'b1;
      step(1);
      rx_frame_mark = 1'b0;
      step(1);
      `CHK("sync wide", 1'(w), rx_sync_pin_out)
    end
    rx_signaling_frame = 1'b0;
    wr(ADDR_RECEIVE_CONTROL_B, 8'h00);
    wr(ADDR_COMMON_CONTROL_A, 8'h04);
    wr(ADDR_RECEIVE_CONTROL_B, 8'h08);
    `CHK("store en", 1'b1, rx_elastic_store_en)
    for (int k = 0; k < 4; k++) begin
      sync_drive = k[0];
      step(5);
      `CHK("sync oe in", 1'b0, rx_sync_pin_oe)
      `CHK("sync ext", k[0], rx_sync_external)
    end
    wr(ADDR_RECEIVE_CONTROL_B, 8'h00);
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h02);
    repeat (8) @(posedge tx_line_clock);
    repeat (6) begin
      @(posedge tx_line_clock);
      #1;
      `CHK("blue", 2'b11, {tx_line_pos_out, tx_line_neg_out})
    end
    step(1);
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h00);
    repeat (8) @(posedge tx_line_clock);
    repeat (20) begin
      @(posedge tx_line_clock);
      #1;
      `CHK("normal line", 1'b0, tx_line_pos_out & tx_line_neg_out)
    end
    step(1);
    // Passed F bits and remote alarm
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h41);
    repeat (400) @(posedge tx_line_clock);
    step(1);
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h80);
    line_run = 1'b0;
    step(80);
    `CHK("clock lost", 1'b1, tx_clock_lost)
    `CHK("on rx clock", 1'b1, tx_clock_on_rx)
    wr(ADDR_TRANSMIT_CONTROL_A, 8'h00);
    step(2);
    `CHK("no fallback", 1'b0, tx_clock_on_rx)
    line_run = 1'b1;
    step(80);
    `CHK("clock back", 1'b0, tx_clock_lost)
    tally_and_finish();
  end
endmodule // tfc_framer_control_bench
